// >>> tsf_pkg.sv
// Shared constants and carrier types for the trim sequence flow-control interpreter.
// Assumes a single 40 MHz clock domain and a byte-wide program store read by address.
package tsf_pkg;

  // ************************************************************
  // Command codes
  // ************************************************************
  localparam logic [7:0] TSF_OP_WAIT_ON_INPUT        = 8'h00F0;
  localparam logic [7:0] TSF_OP_TEST_INPUT_AND_JUMP  = 8'h00F1;
  localparam logic [7:0] TSF_OP_JUMP                 = 8'h00F2;
  localparam logic [7:0] TSF_OP_BUILTIN_TRIM_ROUTINE = 8'h00F3;
  localparam logic [7:0] TSF_OP_PROGRAM_OPEN_MARKER  = 8'h0080;
  localparam logic [7:0] TSF_OP_PROGRAM_CLOSE_MARKER = 8'h0000;

  // ************************************************************
  // Sizes and reset values
  // ************************************************************
  localparam int          TSF_NUM_INPUTS = 20;
  localparam int          TSF_ADDR_W     = 7;
  localparam logic [6:0]  TSF_ADDR_MAX   = 7'h0040;
  localparam logic [6:0]  TSF_PC_RESET   = 7'h0000;
  localparam logic [7:0]  TSF_OP_RESET   = 8'h0000;
  localparam logic [4:0]  TSF_PORT_RESET = 5'h0000;

  // Input port numbering, in order of the machine's switches and sensors
  localparam logic [4:0] TSF_IN_BUTTON_A     = 5'h0000;
  localparam logic [4:0] TSF_IN_EXTERNAL     = 5'h0013;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [7:0] {
    TSF_IDLE    = 8'b0000_0001,
    TSF_FETCH   = 8'b0000_0010,
    TSF_DECODE  = 8'b0000_0100,
    TSF_FIELD1  = 8'b0000_1000,
    TSF_FIELD2  = 8'b0001_0000,
    TSF_WAITIN  = 8'b0010_0000,
    TSF_TRIM    = 8'b0100_0000,
    TSF_EXEC    = 8'b1000_0000
  } tsf_state_e;

  // Program store read port
  typedef struct packed {
    logic [6:0] addr;
    logic       rd;
  } tsf_prog_req_s;

  // Built-in trim routine handshake
  typedef struct packed {
    logic start;
  } tsf_trim_req_s;

endpackage

// >>> tsf_input_sync.sv
// Two-flop synchroniser for the machine's switch, pedal and sensor inputs.
// Assumes the inputs are asynchronous levels; output is safe for any logic on mclk.
`timescale 1ns/100ps
`default_nettype none

module tsf_input_sync #(
  parameter int WIDTH = 20
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] synced
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } tsf_sync_s;

  tsf_sync_s st_q;
  tsf_sync_s st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d        = st_q;
    st_d.meta   = raw;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign synced = st_q.stable;

endmodule

`default_nettype wire

// >>> tsf_interp.sv
// Flow-control interpreter for the thread trimming sequence program.
// Assumes a byte-wide program store with one-cycle read latency and an external
// built-in trim routine that answers start with a one-cycle done pulse.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Wait-on-input F0: read port number, stall until that input is active.
// - Port numbers 0..19 select the twenty machine switches, pedals and sensors.
// - Test-and-jump F1: port number then address 0..64, test input without waiting.
// - Conditional jump taken only when the condition is false; else fall through.
// - Jump F2: load step pointer from its address field and resume there.
// - Program opens with 80 and closes with 00; close marker stops execution.
module tsf_interp #(
  parameter int NUM_INPUTS = tsf_pkg::TSF_NUM_INPUTS
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  run_start,
  input  wire logic [7:0]            prog_data,
  input  wire logic [NUM_INPUTS-1:0] machine_inputs,
  input  wire logic                  trim_done,
  output tsf_pkg::tsf_prog_req_s     prog_req,
  output tsf_pkg::tsf_trim_req_s     trim_req,
  output logic                       running,
  output logic                       bad_program
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    tsf_pkg::tsf_state_e state;
    logic [6:0]          pc;
    logic [7:0]          op;
    logic [4:0]          port;
    logic                rd;
    logic                trim;
    logic                bad;
    logic                opened;
  } tsf_core_s;

  tsf_core_s st_q;
  tsf_core_s st_d;

  logic [NUM_INPUTS-1:0] inputs_s;

  // Switches arrive from the machine unsynchronised
  tsf_input_sync #(
    .WIDTH (NUM_INPUTS)
  ) u_sync (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .raw    (machine_inputs),
    .synced (inputs_s)
  );

  // Input selection by port number; out-of-range ports read as inactive
  function automatic logic port_level(input logic [4:0] num, input logic [NUM_INPUTS-1:0] v);
    logic r;
    r = 1'b0;
    if (num < 5'(NUM_INPUTS)) begin
      r = v[num];
    end
    return r;
  endfunction

  // Clamp-free address check, so a wild target stops rather than runs off
  function automatic logic addr_ok(input logic [7:0] a);
    return a <= {1'b0, tsf_pkg::TSF_ADDR_MAX};
  endfunction

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    st_d      = st_q;
    st_d.rd   = 1'b0;
    st_d.trim = 1'b0;
    case (st_q.state)
      tsf_pkg::TSF_IDLE: begin
        if (run_start) begin
          st_d.pc     = tsf_pkg::TSF_PC_RESET;
          st_d.bad    = 1'b0;
          st_d.opened = 1'b0;
          st_d.rd     = 1'b1;
          st_d.state  = tsf_pkg::TSF_FETCH;
        end
      end
      tsf_pkg::TSF_FETCH: begin
        // Data is valid one cycle after the read strobe
        st_d.state = tsf_pkg::TSF_DECODE;
      end
      tsf_pkg::TSF_DECODE: begin
        st_d.op = prog_data;
        st_d.pc = st_q.pc + 7'h0001;
        if (!st_q.opened) begin
          if (prog_data == tsf_pkg::TSF_OP_PROGRAM_OPEN_MARKER) begin
            st_d.opened = 1'b1;
            st_d.rd     = 1'b1;
            st_d.state  = tsf_pkg::TSF_FETCH;
          end else begin
            st_d.bad   = 1'b1;
            st_d.state = tsf_pkg::TSF_IDLE;
          end
        end else begin
          case (prog_data)
            tsf_pkg::TSF_OP_PROGRAM_CLOSE_MARKER: begin
              st_d.state = tsf_pkg::TSF_IDLE;
            end
            tsf_pkg::TSF_OP_WAIT_ON_INPUT,
            tsf_pkg::TSF_OP_TEST_INPUT_AND_JUMP,
            tsf_pkg::TSF_OP_JUMP: begin
              st_d.rd    = 1'b1;
              st_d.state = tsf_pkg::TSF_FIELD1;
            end
            tsf_pkg::TSF_OP_BUILTIN_TRIM_ROUTINE: begin
              st_d.trim  = 1'b1;
              st_d.state = tsf_pkg::TSF_TRIM;
            end
            default: begin
              // Commands outside this block (speed, solenoids, timers) are skipped
              st_d.rd    = 1'b1;
              st_d.state = tsf_pkg::TSF_FETCH;
            end
          endcase
        end
      end
      tsf_pkg::TSF_FIELD1: begin
        st_d.state = tsf_pkg::TSF_EXEC;
      end
      tsf_pkg::TSF_EXEC: begin
        // First data field now on prog_data
        st_d.pc = st_q.pc + 7'h0001;
        case (st_q.op)
          tsf_pkg::TSF_OP_WAIT_ON_INPUT: begin
            st_d.port  = prog_data[4:0];
            st_d.state = tsf_pkg::TSF_WAITIN;
          end
          tsf_pkg::TSF_OP_TEST_INPUT_AND_JUMP: begin
            st_d.port  = prog_data[4:0];
            st_d.rd    = 1'b1;
            st_d.state = tsf_pkg::TSF_FIELD2;
          end
          default: begin
            if (addr_ok(prog_data)) begin
              st_d.pc    = prog_data[6:0];
              st_d.rd    = 1'b1;
              st_d.state = tsf_pkg::TSF_FETCH;
            end else begin
              st_d.bad   = 1'b1;
              st_d.state = tsf_pkg::TSF_IDLE;
            end
          end
        endcase
      end
      tsf_pkg::TSF_FIELD2: begin
        // Address byte is read one cycle after the strobe; op flips to mark it done
        if (st_q.op == tsf_pkg::TSF_OP_TEST_INPUT_AND_JUMP) begin
          st_d.op = tsf_pkg::TSF_OP_RESET;
        end else begin
          st_d.pc = st_q.pc + 7'h0001;
          st_d.rd = 1'b1;
          if (!port_level(st_q.port, inputs_s)) begin
            if (addr_ok(prog_data)) begin
              st_d.pc = prog_data[6:0];
            end else begin
              st_d.bad   = 1'b1;
              st_d.rd    = 1'b0;
            end
          end
          st_d.state = st_d.bad ? tsf_pkg::TSF_IDLE : tsf_pkg::TSF_FETCH;
        end
      end
      tsf_pkg::TSF_WAITIN: begin
        if (port_level(st_q.port, inputs_s)) begin
          st_d.rd    = 1'b1;
          st_d.state = tsf_pkg::TSF_FETCH;
        end
      end
      tsf_pkg::TSF_TRIM: begin
        if (trim_done) begin
          st_d.rd    = 1'b1;
          st_d.state = tsf_pkg::TSF_FETCH;
        end
      end
      default: begin
        st_d.state = tsf_pkg::TSF_IDLE;
      end
    endcase
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.state  <= tsf_pkg::TSF_IDLE;
      st_q.pc     <= tsf_pkg::TSF_PC_RESET;
      st_q.op     <= tsf_pkg::TSF_OP_RESET;
      st_q.port   <= tsf_pkg::TSF_PORT_RESET;
      st_q.rd     <= 1'b0;
      st_q.trim   <= 1'b0;
      st_q.bad    <= 1'b0;
      st_q.opened <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Read strobe and address come straight from flops
  assign prog_req.addr  = st_q.pc;
  assign prog_req.rd    = st_q.rd;
  assign trim_req.start = st_q.trim;
  assign running        = (st_q.state != tsf_pkg::TSF_IDLE);
  assign bad_program    = st_q.bad;

endmodule

`default_nettype wire

// >>> tsf_chk.sv
// Port checker for the trim sequence interpreter.
// Assumes one mclk domain and an asynchronous active-low rst_n.
`timescale 1ns/100ps
`default_nettype none

module tsf_chk (
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic                   run_start,
  input wire logic                   trim_done,
  input wire tsf_pkg::tsf_prog_req_s prog_req,
  input wire tsf_pkg::tsf_trim_req_s trim_req,
  input wire logic                   running,
  input wire logic                   bad_program
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_start; run_start && !running; endsequence
  sequence s_fetch0; prog_req.rd && prog_req.addr == 7'h00 && running; endsequence
  AST_START_FETCH: assert property (s_start |=> s_fetch0)
    else $error("start did not fetch address zero");
  AST_RD_SPACING: assert property (prog_req.rd |=> !prog_req.rd)
    else $error("program reads too close");
  AST_ADDR_RANGE: assert property (prog_req.rd |-> prog_req.addr <= 7'h40)
    else $error("program read beyond address 64");
  AST_TRIM_PULSE: assert property (trim_req.start |-> running ##1 !trim_req.start && !prog_req.rd)
    else $error("trim start malformed");
  AST_TRIM_RESUME: assert property (trim_done && running |-> ##[1:4] prog_req.rd)
    else $error("no fetch after trim finished");
  AST_BAD_STOPS: assert property ($rose(bad_program) |-> ##[0:2] !running)
    else $error("bad program kept running");
  // Idle means nothing may be requested
  AST_IDLE_QUIET: assert property (!running |-> !prog_req.rd && !trim_req.start)
    else $error("request while idle");
endmodule

bind tsf_interp tsf_chk tsf_chk_inst (.mclk(mclk), .rst_n(rst_n), .run_start(run_start),
  .trim_done(trim_done), .prog_req(prog_req), .trim_req(trim_req), .running(running),
  .bad_program(bad_program));
`default_nettype wire

// >>> tsf_machine_model.sv
// Model of program store, trim routine and machine switches.
// Assumes reads are one-cycle rd pulses; data is lost two cycles after.
`timescale 1ns/100ps
`default_nettype none

module tsf_machine_model (
  input  wire logic                   mclk,
  input  wire tsf_pkg::tsf_prog_req_s prog_req,
  input  wire tsf_pkg::tsf_trim_req_s trim_req,
  output logic [7:0]                  prog_data,
  output logic [19:0]                 machine_inputs,
  output logic                        trim_done
);
  // ****************************************
  // Store and trim routine
  // ****************************************
  logic [7:0]  mem [0:64];
  logic [19:0] sw;
  int          trim_dly;
  int          trims;
  int          age;
  int          tcnt;
  initial begin
    for (int i = 0; i < 65; i++) mem[i] = 8'h00;
    prog_data = 8'h00;
    trim_done = 1'b0;
    sw = 20'h0_0000;
    trims = 0;
    age = 3;
    tcnt = 0;
    trim_dly = 1;
  end
  assign machine_inputs = sw;
  // Stale byte is inverted so a late fetch cannot pass by luck
  always @(posedge mclk) begin
    if (age < 3) age <= age + 1;
    if (prog_req.rd) begin
      prog_data <= mem[prog_req.addr];
      age <= 0;
    end else if (age == 1) prog_data <= ~prog_data;
    trim_done <= 1'b0;
    if (trim_req.start) begin
      tcnt <= trim_dly;
      trims <= trims + 1;
    end else if (tcnt == 1) begin
      trim_done <= 1'b1;
      tcnt <= 0;
    end else if (tcnt > 1) tcnt <= tcnt - 1;
  end
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the trim sequence interpreter.
// Assumes the machine model serves program bytes and trim handshakes.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  // ****************************************
  // Harness and tests
  // ****************************************
  logic                   mclk;
  logic                   rst_n;
  logic                   run_start;
  logic [7:0]             prog_data;
  logic [19:0]            machine_inputs;
  logic                   trim_done;
  logic                   running;
  logic                   bad_program;
  tsf_pkg::tsf_prog_req_s prog_req;
  tsf_pkg::tsf_trim_req_s trim_req;
  int                     n_errors;
  int                     checks;
  int                     base;
  tsf_interp tsf_interp_inst (.mclk(mclk), .rst_n(rst_n), .run_start(run_start),
    .prog_data(prog_data), .machine_inputs(machine_inputs), .trim_done(trim_done),
    .prog_req(prog_req), .trim_req(trim_req), .running(running), .bad_program(bad_program));
  tsf_machine_model tsf_machine_model_inst (.mclk(mclk), .prog_req(prog_req),
    .trim_req(trim_req), .prog_data(prog_data), .machine_inputs(machine_inputs),
    .trim_done(trim_done));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] tr();
    return 8'(tsf_machine_model_inst.trims - base);
  endfunction
  // Load eight bytes and start; inputs settle through the synchroniser first
  task automatic start(input logic [63:0] p);
    for (int i = 0; i < 8; i++) tsf_machine_model_inst.mem[i] = p[63-8*i -: 8];
    base = tsf_machine_model_inst.trims;
    repeat (4) @(posedge mclk);
    run_start <= 1'b1;
    @(posedge mclk);
    run_start <= 1'b0;
  endtask
  task automatic go(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (running === 1'b1 && n < lim);
  endtask
  task automatic t_bad;
    start(64'h81F3_0000_0000_0000);
    go(20);
    cmp("running", 8'h00, {7'h00, running});
    cmp("bad_program", 8'h01, {7'h00, bad_program});
    cmp("trims", 8'h00, tr());
    start(64'h80F2_41F3_0000_0000);
    go(20);
    cmp("running", 8'h00, {7'h00, running});
    cmp("bad_program", 8'h01, {7'h00, bad_program});
    $display("test bad done");
  endtask
  // Unknown byte A5 is skipped on the way to the jump
  task automatic t_jump;
    start(64'h80A5_F206_F3F3_0000);
    go(40);
    cmp("running", 8'h00, {7'h00, running});
    cmp("bad_program", 8'h00, {7'h00, bad_program});
    cmp("trims", 8'h00, tr());
    // Port 20 does not exist, so it reads inactive and the jump is taken
    @(posedge mclk);
    tsf_machine_model_inst.sw <= 20'hF_FFFF;
    start(64'h80F1_1407_F300_0000);
    go(40);
    cmp("running", 8'h00, {7'h00, running});
    cmp("port 20 trims", 8'h00, tr());
    $display("test jump done");
  endtask
  task automatic t_trim(input int dly);
    tsf_machine_model_inst.trim_dly = dly;
    start(64'h80F3_F300_0000_0000);
    go(150);
    cmp("trims", 8'h02, tr());
    cmp("running", 8'h00, {7'h00, running});
    $display("test trim done");
  endtask
  // Other ports held opposite so a wrong port number is seen
  task automatic t_branch;
    logic [4:0] p;
    for (int k = 0; k < 4; k++) begin
      p = k[1] ? 5'h13 : 5'h00;
      @(posedge mclk);
      tsf_machine_model_inst.sw <= k[0] ? (20'h1 << p) : ~(20'h1 << p);
      start({16'h80F1, 3'b000, p, 40'h06F3_0000_00});
      go(60);
      cmp("running", 8'h00, {7'h00, running});
      cmp("branch trims", {7'h00, k[0]}, tr());
    end
    $display("test branch done");
  endtask
  task automatic t_wait;
    @(posedge mclk);
    tsf_machine_model_inst.sw <= 20'hF_EFFF;
    start(64'h80F0_0CF3_0000_0000);
    go(40);
    cmp("running", 8'h01, {7'h00, running});
    cmp("trims", 8'h00, tr());
    @(posedge mclk);
    tsf_machine_model_inst.sw <= 20'h0_1000;
    go(40);
    cmp("trims", 8'h01, tr());
    cmp("running", 8'h00, {7'h00, running});
    $display("test wait done");
  endtask
  // Reset in mid-run drops a stalled program; a fresh start works after it
  task automatic t_reset;
    @(posedge mclk);
    tsf_machine_model_inst.sw <= 20'h0_0000;
    start(64'h80F0_0300_0000_0000);
    go(20);
    cmp("running", 8'h01, {7'h00, running});
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    cmp("reset running", 8'h00, {7'h00, running});
    cmp("reset rd", 8'h00, {7'h00, prog_req.rd});
    @(posedge mclk);
    rst_n <= 1'b1;
    start(64'h80F3_0000_0000_0000);
    go(60);
    cmp("trims", 8'h01, tr());
    cmp("running", 8'h00, {7'h00, running});
    $display("test reset done");
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Whole sequence needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    close_out;
  end
  initial begin
    rst_n = 1'b0;
    run_start = 1'b0;
    n_errors = 0;
    checks = 0;
    base = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_bad;
    t_jump;
    t_trim(1);
    t_trim(25);
    t_branch;
    t_wait;
    t_reset;
    close_out;
  end
endmodule
`default_nettype wire
